// ---- ubr_baud_gen.sv ----
// Baud rate generator with Avalon-MM registers and interrupt status.
//
// Summary of operation
// - One 8 or 16-bit timer, both modes.
// - Reset to 8-bit; wide only when selected.
// - Timer free-runs; period set by divisor.
// - Async multiplier from high-speed and wide bits.
// - Sync mode ignores the high-speed bit.
// - Divisor write clears timer at once.
// - Async narrow normal: clock over 64(n+1).
// - Async wide normal: clock over 16(n+1).
// - Sync: clock over 4(n+1), either width.
// - Divisor is high byte over low byte.
`timescale 1ns/1ps
module ubr_baud_gen
    import ubr_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 srst,
    input  wire logic [ADDR_W-1:0]    avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    output logic      [31:0]          avs_readdata,
    output logic                      avs_waitrequest,
    input  wire logic                 receive_idle_flag,
    input  wire logic                 receive_int_flag,
    input  wire logic                 auto_rate_done,
    input  wire logic                 auto_rate_overflow,
    output logic                      rate_tick,
    output logic                      sync_mode,
    output logic                      high_speed_select,
    output logic                      wide_divider_select,
    output logic                      clock_polarity_select,
    output logic                      wake_on_edge_enable,
    output logic                      auto_rate_detect_enable,
    output logic                      irq
);
    import ubr_pkg::*;

    // Whole register state of the front end.
    typedef struct packed {
        logic            ack;     // Second cycle of a bus access.
        logic [31:0]     rdata;   // Registered read data.
        logic [7:0]      div_lo;  // divisor_low.
        logic [7:0]      div_hi;  // divisor_high.
        logic            clr;     // Timer restart pulse.
        logic            pol;     // clock_polarity_select.
        logic            wide;    // wide_divider_select.
        logic            wake;    // wake_on_edge_enable.
        logic            auto;    // auto_rate_detect_enable.
        logic            sync;    // Synchronous mode.
        logic            hs;      // high_speed_select.
        logic            ovf_q;   // Last overflow level, for edge detect.
        logic [EV_W-1:0] status;  // Sticky event bits.
        logic [EV_W-1:0] mask;    // Interrupt enables.
    } ubr_regs_s;

    ubr_regs_s       st_reg;     // Current state.
    ubr_regs_s       st_next;    // Next state.
    logic            req;        // A bus request is present.
    logic            wr_done;    // A write takes effect at this edge.
    logic [EV_W-1:0] ev;         // Events raised this cycle.
    logic [31:0]     rd_mux;     // Read data before registering.
    logic [7:0]      ctrl_view;  // baud_control as software sees it.
    ubr_mult_e       mult_sel;   // Multiplier chosen from the mode bits.

    ubr_timer_if tif ();

    // The timer itself; one instance serves both sync and async modes.
    ubr_rate_timer u_timer (
        .clk  (clk),
        .srst (srst),
        .t    (tif)
    );

    // Every access costs exactly one wait cycle; the answer comes
    // on the second edge, which keeps the read path fully registered.
    // The price is that back-to-back transfers cost two cycles each.
    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~st_reg.ack;
    assign wr_done         = avs_write & st_reg.ack;
    assign avs_readdata    = st_reg.rdata;

    // Software view of baud_control; unimplemented bits read as zero.
    always_comb begin
        ctrl_view          = 8'h00;
        ctrl_view[CB_OVF]  = auto_rate_overflow;
        ctrl_view[CB_IDLE] = receive_idle_flag;
        ctrl_view[CB_POL]  = st_reg.pol;
        ctrl_view[CB_WIDE] = st_reg.wide;
        ctrl_view[CB_WAKE] = st_reg.wake;
        ctrl_view[CB_AUTO] = st_reg.auto;
    end

    // Read multiplexer; an unmapped address reads as zero.
    always_comb begin
        rd_mux = 32'h00000000;
        if (avs_address == OFF_DIV_LO) begin
            rd_mux[7:0] = st_reg.div_lo;
        end else if (avs_address == OFF_DIV_HI) begin
            rd_mux[7:0] = st_reg.div_hi;
        end else if (avs_address == OFF_CTRL) begin
            rd_mux[7:0] = ctrl_view;
        end else if (avs_address == OFF_MODE) begin
            rd_mux[MB_SYNC] = st_reg.sync;
            rd_mux[MB_HS]   = st_reg.hs;
        end else if (avs_address == OFF_STATUS) begin
            rd_mux[EV_W-1:0] = st_reg.status;
        end else if (avs_address == OFF_MASK) begin
            rd_mux[EV_W-1:0] = st_reg.mask;
        end
    end

    // The mode bits are plain register bits, so a change reaches the timer
    // on the next clock; it is not held off until the next tick, and the
    // period in which it lands is of mixed length.
    // Multiplier selection. In sync mode the high-speed bit is a
    // don't-care, so it is simply not looked at on that branch.
    always_comb begin
        if (st_reg.sync) begin
            mult_sel = UBR_MUL4;
        end else if (st_reg.wide && st_reg.hs) begin
            mult_sel = UBR_MUL4;
        end else if (st_reg.wide || st_reg.hs) begin
            mult_sel = UBR_MUL16;
        end else begin
            mult_sel = UBR_MUL64;
        end
    end

    // Timer steering; the divisor pair forms one 16-bit value.
    // Both bytes feed the timer at once, so the first byte written runs briefly
    // with a mixed divisor; the second byte's write restarts the count cleanly.
    assign tif.clear   = st_reg.clr;
    assign tif.mult    = mult_sel;
    assign tif.wide    = st_reg.wide;
    assign tif.divisor = {st_reg.div_hi, st_reg.div_lo};
    assign rate_tick   = tif.tick;

    // Mode outputs come straight from the registers.
    // The shift paths read them directly; no second copy is kept here.
    assign sync_mode               = st_reg.sync;
    assign high_speed_select       = st_reg.hs;
    assign wide_divider_select     = st_reg.wide;
    assign clock_polarity_select   = st_reg.pol;
    assign wake_on_edge_enable     = st_reg.wake;
    assign auto_rate_detect_enable = st_reg.auto;

    // One level interrupt for any unmasked sticky bit. It is formed from two
    // registers only, so it cannot glitch; it drops in the cycle after
    // software clears the status bit or the mask.
    assign irq = |(st_reg.status & st_reg.mask);

    // Next-state logic for the whole front end.
    always_comb begin
        st_next     = st_reg;
        st_next.ack = req & ~st_reg.ack;
        st_next.clr = 1'b0;
        ev          = '0;
        // Read data is captured on the first edge so it stands
        // throughout the cycle in which waitrequest is low.
        if (avs_read && !st_reg.ack) begin
            st_next.rdata = rd_mux;
        end
        // Self-clearing enables only act in asynchronous mode.
        if (!st_reg.sync && st_reg.wake && receive_int_flag) begin
            st_next.wake = 1'b0;
            ev[SB_WAKE]  = 1'b1;
        end
        if (!st_reg.sync && st_reg.auto && auto_rate_done) begin
            st_next.auto = 1'b0;
            ev[SB_AUTO]  = 1'b1;
        end
        // Overflow is a level from the measurement logic; flag its rise.
        st_next.ovf_q = auto_rate_overflow;
        if (auto_rate_overflow && !st_reg.ovf_q) begin
            ev[SB_OVF] = 1'b1;
        end
        // Software writes land after the self-clears, so a write of an
        // enable in the same cycle as its self-clear keeps the write.
        if (wr_done) begin
            if (avs_address == OFF_DIV_LO) begin
                st_next.div_lo = avs_writedata[7:0];
                st_next.clr    = 1'b1;
            end else if (avs_address == OFF_DIV_HI) begin
                st_next.div_hi = avs_writedata[7:0];
                st_next.clr    = 1'b1;
            end else if (avs_address == OFF_CTRL) begin
                st_next.pol  = avs_writedata[CB_POL];
                st_next.wide = avs_writedata[CB_WIDE];
                st_next.wake = avs_writedata[CB_WAKE];
                st_next.auto = avs_writedata[CB_AUTO];
            end else if (avs_address == OFF_MODE) begin
                st_next.sync = avs_writedata[MB_SYNC];
                st_next.hs   = avs_writedata[MB_HS];
            end else if (avs_address == OFF_STATUS) begin
                // Write one to clear.
                st_next.status = st_reg.status & ~avs_writedata[EV_W-1:0];
            end else if (avs_address == OFF_MASK) begin
                st_next.mask = avs_writedata[EV_W-1:0];
            end
        end
        // Sets are applied last so an event beats a clear in the same cycle.
        st_next.status = st_next.status | ev;
    end

    // State register; every control bit has a defined reset value.
    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg <= '{
                ack:    1'b0,
                rdata:  32'h00000000,
                div_lo: DIV_RESET,
                div_hi: DIV_RESET,
                clr:    1'b0,
                pol:    1'b0,
                wide:   1'b0,
                wake:   1'b0,
                auto:   1'b0,
                sync:   1'b0,
                hs:     1'b0,
                ovf_q:  1'b0,
                status: '0,
                mask:   MASK_RESET
            };
        end else begin
            st_reg <= st_next;
        end
    end

    // Checks on the front end, all on the one clock domain.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // The write target of the current access, for the checks below.
    logic wr_div;
    logic wr_ctrl;
    assign wr_div  = wr_done && (avs_address == OFF_DIV_LO || avs_address == OFF_DIV_HI);
    assign wr_ctrl = wr_done && avs_address == OFF_CTRL;

    a_wide_after_reset: assert property ($fell(srst) |-> !wide_divider_select && !tif.wide)
        else $error("Divider is not narrow after reset.");

    a_sync_mult: assert property (sync_mode |-> tif.mult == UBR_MUL4)
        else $error("Sync mode multiplier is not four.");

    a_async_narrow: assert property (!sync_mode && !wide_divider_select && !high_speed_select
        |-> tif.mult == UBR_MUL64)
        else $error("Async narrow normal multiplier is not sixty-four.");

    a_async_wide: assert property (!sync_mode && wide_divider_select && !high_speed_select
        |-> tif.mult == UBR_MUL16)
        else $error("Async wide normal multiplier is not sixteen.");

    a_async_fast: assert property (!sync_mode && high_speed_select
        |-> tif.mult == (wide_divider_select ? UBR_MUL4 : UBR_MUL16))
        else $error("Async high-speed multiplier is wrong.");

    a_div_clear: assert property (wr_div |=> tif.clear ##1 !tif.clear)
        else $error("Divisor write did not restart the timer for one cycle.");

    a_div_concat: assert property (wr_done && avs_address == OFF_DIV_HI
        |=> tif.divisor[15:8] == $past(avs_writedata[7:0]))
        else $error("High divisor byte is not the upper half of the divisor.");

    a_wake_selfclr: assert property (wake_on_edge_enable && !sync_mode && receive_int_flag && !wr_ctrl
        |=> !wake_on_edge_enable && st_reg.status[SB_WAKE])
        else $error("Wake enable did not clear on the receive flag.");

    a_auto_selfclr: assert property (auto_rate_detect_enable && !sync_mode && auto_rate_done && !wr_ctrl
        |=> !auto_rate_detect_enable && st_reg.status[SB_AUTO])
        else $error("Auto-rate enable did not clear on completion.");

    a_wait_one: assert property (req && !st_reg.ack |-> avs_waitrequest ##1 (!req || !avs_waitrequest))
        else $error("Bus access did not complete after one wait cycle.");

    // The self-clears are asynchronous-mode behaviour only; in sync mode an
    // enable must survive the very flags that would clear it otherwise.
    a_sync_keep_wake: assert property (sync_mode && wake_on_edge_enable && !wr_ctrl
        |=> wake_on_edge_enable)
        else $error("Wake enable cleared itself in synchronous mode.");

    a_sync_keep_auto: assert property (sync_mode && auto_rate_detect_enable && !wr_ctrl
        |=> auto_rate_detect_enable)
        else $error("Auto-rate enable cleared itself in synchronous mode.");

    // A rising overflow level must always be recorded, whatever the bus does.
    a_ovf_sticky: assert property ($rose(auto_rate_overflow) |=> st_reg.status[SB_OVF])
        else $error("Overflow rise was not recorded in the status register.");

    // A recorded event stays until software writes a one to its bit.
    a_status_hold: assert property (st_reg.status[SB_WAKE]
        && !(wr_done && avs_address == OFF_STATUS && avs_writedata[SB_WAKE])
        |=> st_reg.status[SB_WAKE])
        else $error("Wake status bit cleared without a software clear.");

endmodule

// ---- ubr_baud_gen_tb_top.sv ----
// Self-checking testbench for the baud rate generator registers, rate tick and interrupt.
`timescale 1ns/1ps
module ubr_baud_gen_tb_top;
    import ubr_pkg::*;

    logic              clk                     = 1'b0;  // System clock, 100 MHz.
    logic              srst                    = 1'b1;  // Synchronous reset, active high.
    logic [ADDR_W-1:0] avs_address             = '0;    // Bus byte address.
    logic              avs_read                = 1'b0;  // Bus read request.
    logic              avs_write               = 1'b0;  // Bus write request.
    logic [31:0]       avs_writedata           = '0;    // Bus write data.
    logic [31:0]       avs_readdata;                    // Bus read data.
    logic              avs_waitrequest;                 // Bus stall.
    logic              receive_idle_flag       = 1'b1;  // Receiver reports idle.
    logic              receive_int_flag        = 1'b0;  // Receiver flag event.
    logic              auto_rate_done          = 1'b0;  // Measurement complete event.
    logic              auto_rate_overflow      = 1'b0;  // Measurement overflow level.
    logic              rate_tick;                       // Bit-rate tick.
    logic              sync_mode;                       // Mode outputs.
    logic              high_speed_select;
    logic              wide_divider_select;
    logic              clock_polarity_select;
    logic              wake_on_edge_enable;
    logic              auto_rate_detect_enable;
    logic              irq;                             // Level interrupt.
    int                failures                = 0;     // Mismatches seen.
    int                n_checks                = 0;     // Comparisons made.
    logic [31:0]       q;                               // Scratch read data.

    ubr_baud_gen u_dut (.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .receive_idle_flag(receive_idle_flag),
        .receive_int_flag(receive_int_flag), .auto_rate_done(auto_rate_done),
        .auto_rate_overflow(auto_rate_overflow), .rate_tick(rate_tick), .sync_mode(sync_mode),
        .high_speed_select(high_speed_select), .wide_divider_select(wide_divider_select),
        .clock_polarity_select(clock_polarity_select), .wake_on_edge_enable(wake_on_edge_enable),
        .auto_rate_detect_enable(auto_rate_detect_enable), .irq(irq));

    // The clock toggles every half period.
    always #5 clk = ~clk;

    // Compares one value and reports a mismatch at once.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic final_report();
        if (failures == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One bus transfer; the request is held until waitrequest is seen low at a rising edge.
    // Code right after an edge still sees the values from before it, so waitrequest and
    // read data are taken at the very edge that completes the transfer.
    // The opening edge keeps one idle cycle between back-to-back transfers.
    task automatic bus_xfer(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !wr;
        avs_write     <= wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) begin
            failures++;
        end
        r = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // Register write.
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus_xfer(1'b1, a, d, r);
    endtask

    // Register read compared with an expected value.
    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus_xfer(1'b0, a, 32'h0, r);
        check($sformatf("read %h", a), r, exp);
    endtask

    // Counts cycles from a completed divisor write to the first two ticks.
    // A tick in the first two cycles after the write may be a leftover and is skipped.
    task automatic measure(input int p);
        int j;
        int first;
        int second;
        first = -1;
        second = -1;
        for (j = 0; j < 3 * p + 10 && second < 0; j++) begin
            @(negedge clk);
            if (rate_tick === 1'b1 && j > 1) begin
                if (first < 0) first = j;
                else second = j;
            end
        end
        check($sformatf("first tick P=%0d", p), first, p + 1);
        check($sformatf("tick period P=%0d", p), second - first, p);
    endtask

    // Watchdog: the tests need about 15500 cycles.
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        final_report();
    end

    // Main test sequence.
    initial begin
        int m;
        int n;
        logic [2:0] c;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        // Reset values, then an unmapped place that reads zero and ignores writes.
        rd(OFF_DIV_LO, 32'h0);
        rd(OFF_DIV_HI, 32'h0);
        rd(OFF_CTRL, 32'h40);
        rd(OFF_MODE, 32'h0);
        rd(OFF_STATUS, 32'h0);
        rd(OFF_MASK, 32'h0);
        wr(5'h18, 32'hFF);
        rd(5'h18, 32'h0);
        #1 check("wide after reset", wide_divider_select, 1'b0);
        // Every mode combination; the divisor pair is 0x0102, narrow width uses the low byte only.
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            m = c[2] ? 4 : (c[1] & c[0]) ? 4 : (c[1] ^ c[0]) ? 16 : 64;
            n = c[1] ? 258 : 2;
            wr(OFF_MODE, (32'(c[2]) << MB_SYNC) | (32'(c[0]) << MB_HS));
            wr(OFF_CTRL, 32'(c[1]) << CB_WIDE);
            wr(OFF_DIV_HI, 32'h01);
            // Writing the low byte in mid-count must restart the period at once.
            repeat (30) @(posedge clk);
            wr(OFF_DIV_LO, 32'h02);
            #1 check("sync out", sync_mode, c[2]);
            check("hs out", high_speed_select, c[0]);
            check("wide out", wide_divider_select, c[1]);
            measure(m * (n + 1));
            @(posedge clk);
        end
        rd(OFF_DIV_HI, 32'h01);
        rd(OFF_DIV_LO, 32'h02);
        // Events, sticky status, mask and the self-clearing enables in asynchronous mode.
        wr(OFF_MODE, 32'h0);
        wr(OFF_CTRL, (32'h1 << CB_WAKE) | (32'h1 << CB_AUTO) | (32'h1 << CB_POL));
        #1 check("wake en", wake_on_edge_enable, 1'b1);
        check("auto en", auto_rate_detect_enable, 1'b1);
        check("polarity", clock_polarity_select, 1'b1);
        @(posedge clk);
        receive_int_flag <= 1'b1;
        @(posedge clk);
        receive_int_flag <= 1'b0;
        repeat (3) @(posedge clk);
        #1 check("wake self clear", wake_on_edge_enable, 1'b0);
        check("auto kept", auto_rate_detect_enable, 1'b1);
        check("irq masked", irq, 1'b0);
        rd(OFF_STATUS, 32'h1);
        wr(OFF_MASK, 32'h7);
        rd(OFF_MASK, 32'h7);
        #1 check("irq raised", irq, 1'b1);
        @(posedge clk);
        auto_rate_done <= 1'b1;
        @(posedge clk);
        auto_rate_done <= 1'b0;
        auto_rate_overflow <= 1'b1;
        repeat (3) @(posedge clk);
        #1 check("auto self clear", auto_rate_detect_enable, 1'b0);
        rd(OFF_STATUS, 32'h7);
        rd(OFF_CTRL, 32'hD0);
        wr(OFF_STATUS, 32'h3);
        rd(OFF_STATUS, 32'h4);
        #1 check("irq overflow", irq, 1'b1);
        wr(OFF_MASK, 32'h3);
        #1 check("irq remasked", irq, 1'b0);
        wr(OFF_STATUS, 32'h4);
        rd(OFF_STATUS, 32'h0);
        // Sync mode keeps both enables through their events; a busy receiver reads as not idle.
        wr(OFF_MODE, 32'h1 << MB_SYNC);
        wr(OFF_CTRL, (32'h1 << CB_WAKE) | (32'h1 << CB_AUTO));
        receive_int_flag  <= 1'b1;
        auto_rate_done    <= 1'b1;
        receive_idle_flag <= 1'b0;
        @(posedge clk);
        receive_int_flag  <= 1'b0;
        auto_rate_done    <= 1'b0;
        rd(OFF_CTRL, 32'h83);
        rd(OFF_STATUS, 32'h0);
        repeat (2) @(posedge clk);
        final_report();
    end
endmodule

// ---- ubr_pkg.sv ----
// Shared constants and types for the baud rate generator block.
package ubr_pkg;

    // Register byte addresses on the bus; each register takes one aligned word.
    localparam int          ADDR_W      = 5;
    localparam logic [4:0]  OFF_DIV_LO  = 5'h00;
    localparam logic [4:0]  OFF_DIV_HI  = 5'h04;
    localparam logic [4:0]  OFF_CTRL    = 5'h08;
    localparam logic [4:0]  OFF_MODE    = 5'h0C;
    localparam logic [4:0]  OFF_STATUS  = 5'h10;
    localparam logic [4:0]  OFF_MASK    = 5'h14;

    // Bit positions inside the baud_control register.
    localparam int CB_OVF  = 7;
    localparam int CB_IDLE = 6;
    localparam int CB_POL  = 4;
    localparam int CB_WIDE = 3;
    localparam int CB_WAKE = 1;
    localparam int CB_AUTO = 0;

    // Bit positions inside the mode register.
    localparam int MB_SYNC = 0;
    localparam int MB_HS   = 1;

    // Event bits of the status and mask registers.
    localparam int EV_W    = 3;
    localparam int SB_WAKE = 0;
    localparam int SB_AUTO = 1;
    localparam int SB_OVF  = 2;

    // Reset values of the software-written fields.
    localparam logic [7:0]      DIV_RESET  = 8'h00;
    localparam logic [EV_W-1:0] MASK_RESET = 3'h0;

    // Clock cycles spent per divisor step, as selected by the mode bits.
    typedef enum logic [1:0] {
        UBR_MUL64 = 2'h0,
        UBR_MUL16 = 2'h1,
        UBR_MUL4  = 2'h2
    } ubr_mult_e;

    // Last prescaler count for each multiplier (multiplier minus one).
    localparam logic [5:0] PRE_LAST_64 = 6'h3F;
    localparam logic [5:0] PRE_LAST_16 = 6'h0F;
    localparam logic [5:0] PRE_LAST_4  = 6'h03;

endpackage

// ---- ubr_rate_timer.sv ----
// Free-running rate timer: prescaler plus 8/16-bit divisor counter.
`timescale 1ns/1ps
module ubr_rate_timer
    import ubr_pkg::*;
(
    input  wire logic clk,
    input  wire logic srst,
    ubr_timer_if.tmr  t
);
    import ubr_pkg::*;

    // Whole state of the timer.
    typedef struct packed {
        logic [5:0]  pre;   // Prescaler count.
        logic [15:0] cnt;   // Divisor step count.
        logic        tick;  // Registered tick.
    } ubr_tmr_s;

    ubr_tmr_s   st_reg;    // Current state.
    ubr_tmr_s   st_next;   // Next state.
    logic [5:0] pre_last;  // Prescaler terminal count.
    logic [15:0] n_eff;    // Divisor as seen at the current width.

    // Next-state logic. Compares use >= so that a mode change mid-count
    // wraps at once instead of running the counter all the way round.
    always_comb begin
        st_next      = st_reg;
        st_next.tick = 1'b0;
        case (t.mult)
            UBR_MUL64: pre_last = PRE_LAST_64;
            UBR_MUL16: pre_last = PRE_LAST_16;
            default:   pre_last = PRE_LAST_4;
        endcase
        // Narrow mode looks at the low byte only.
        n_eff = t.wide ? t.divisor : {8'h00, t.divisor[7:0]};
        if (t.clear) begin
            // A divisor write restarts the period from zero.
            st_next.pre = 6'h00;
            st_next.cnt = 16'h0000;
        end else if (st_reg.pre >= pre_last) begin
            st_next.pre = 6'h00;
            if (st_reg.cnt >= n_eff) begin
                // Period is multiplier times divisor plus one.
                st_next.cnt  = 16'h0000;
                st_next.tick = 1'b1;
            end else begin
                st_next.cnt = st_reg.cnt + 16'h0001;
            end
        end else begin
            st_next.pre = st_reg.pre + 6'h01;
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg <= '{pre: 6'h00, cnt: 16'h0000, tick: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign t.tick = st_reg.tick;

    // Helper for the period check: cycles since restart and config stability.
    logic [23:0] gap;
    logic [23:0] period;
    logic        clean;
    logic [18:0] cfg_q;
    assign period = 24'({18'h00000, pre_last} + 24'h000001) * 24'({8'h00, n_eff} + 24'h000001);
    always_ff @(posedge clk) begin
        cfg_q <= {t.mult, t.wide, t.divisor};
        if (srst || t.clear || st_next.tick) begin
            gap   <= 24'h000000;
            clean <= ~srst;
        end else begin
            gap <= gap + 24'h000001;
            if (cfg_q != {t.mult, t.wide, t.divisor}) begin
                clean <= 1'b0;
            end
        end
    end

    a_tick_period: assert property (@(posedge clk) disable iff (srst)
        st_reg.tick && $past(clean) && cfg_q == {t.mult, t.wide, t.divisor} |-> $past(gap) == period - 24'h000001)
        else $error("Rate tick period does not match multiplier times divisor plus one.");

    a_clear_restart: assert property (@(posedge clk) disable iff (srst)
        t.clear |=> !st_reg.tick [*3])
        else $error("Rate tick came too soon after a timer clear.");

endmodule

// ---- ubr_timer_if.sv ----
// Interface between the register front end and the rate timer.
`timescale 1ns/1ps
interface ubr_timer_if;
    import ubr_pkg::*;

    logic      clear;   // One-cycle restart of the timer.
    ubr_mult_e mult;    // Cycles per divisor step.
    logic      wide;    // Full 16-bit divisor when high.
    logic [15:0] divisor; // Divisor pair, high byte over low byte.
    logic      tick;    // One-cycle bit-rate tick.

    // The register side steers the timer.
    modport ctl (output clear, output mult, output wide, output divisor, input tick);
    // The timer side counts and reports ticks.
    modport tmr (input clear, input mult, input wide, input divisor, output tick);
endinterface
